// ---- i2c_host_ctrl.sv ----
// What this block does
// - scl period never shorter than 2.5 us, i.e. at most 400 kHz.
// - this controller drives scl and opens every transfer; a device holding released scl low stretches the clock.
// - each byte is eight bits msb first plus one acknowledge clock.
// - sda changes only while scl is low, except at start, repeated start and stop; one bit per scl cycle.
// - never a stop in the same scl high period as a start.
// - during reads this controller acknowledges every byte but the last.
// - last read byte gets a not-acknowledge, then a stop.
// - write is start, address with bit 0, pointer, data, stop.
// - read is pointer write, repeated start, address with bit 1, data.
// - with no transfer both lines are released and rest high.
`timescale 1ns/10ps
`default_nettype none

module i2c_host_ctrl
  import i2c_host_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cmd_valid,
  output logic      cmd_ready,
  input  wire cmd_s cmd,
  output logic      rsp_valid,
  output rsp_s      rsp,
  output logic      done,
  output logic      done_nack,
  output logic      busy,
  input  wire logic address_strap_pin,
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      scl_oe,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe
);

  logic [1:0]       rst_ff;
  logic             rst_sync_n;
  logic             scl_s;
  logic             sda_s;
  logic             strap_s;

  state_e           st_ff;
  state_e           nxt_st;
  phase_e           ph_ff;
  phase_e           nxt_ph;
  logic [1:0]       q_ff;
  logic [1:0]       nxt_q;
  logic [QTR_W-1:0] qcnt_ff;
  logic [QTR_W-1:0] nxt_qcnt;
  logic [3:0]       bit_ff;
  logic [3:0]       nxt_bit;
  logic [7:0]       sh_ff;
  logic [7:0]       nxt_sh;
  cmd_s             cmd_ff;
  cmd_s             nxt_cmd;
  logic             strap_ff;
  logic             nxt_strap;
  logic [2:0]       left_ff;
  logic [2:0]       nxt_left;
  logic             nack_ff;
  logic             nxt_nack;
  rsp_s             rsp_ff;
  rsp_s             nxt_rsp;
  logic             rsp_valid_ff;
  logic             nxt_rsp_valid;
  logic             done_ff;
  logic             nxt_done;
  logic             scl_oe_ff;
  logic             nxt_scl_oe;
  logic             sda_oe_ff;
  logic             nxt_sda_oe;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'h1};
    end
  end
  assign rst_sync_n = rst_ff[1];

  pin_sync u_scl_sync (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (scl_i),
    .level      (scl_s)
  );

  pin_sync u_sda_sync (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (sda_i),
    .level      (sda_s)
  );

  pin_sync u_strap_sync (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .pin        (address_strap_pin),
    .level      (strap_s)
  );

  // decode
  wire idle      = (st_ff == ST_IDLE);
  wire start_cmd = idle && cmd_valid;
  // released scl still low: wait for the line before timing the high phase
  wire scl_hold  = !scl_oe_ff && !scl_s;
  wire qtick     = (qcnt_ff == QTR_LAST);
  wire tx_mode   = (ph_ff != PH_READ);
  wire ack_slot  = (bit_ff == BIT_ACK);
  wire last_read = (left_ff == 3'h0);
  wire dev_nack  = sda_s;
  // ack every read byte but the last; release for the sensor's ack
  wire ack_drive = !tx_mode && !last_read;
  wire bit_low   = ack_slot ? ack_drive : (tx_mode && !sh_ff[7]);
  wire q_low     = (q_ff == Q_LOW);
  wire q_fall    = (q_ff == Q_FALL);
  wire q_high    = (q_ff == Q_HIGH);

  // scl released in the high quarters; pulled low in both low quarters except q_low of a start and q_fall of a stop
  assign nxt_scl_oe =
    (st_ff == ST_START)  ? q_fall :
    (st_ff == ST_RSTART) ? (q_low || q_fall) :
    (st_ff == ST_BYTE)   ? (q_low || q_fall) :
    (st_ff == ST_STOP)   ? q_low :
    1'h0;

  // sda moves only in q_low of a bit, so it is steady across scl high
  assign nxt_sda_oe =
    (st_ff == ST_START)  ? !q_low :
    (st_ff == ST_RSTART) ? (q_high || q_fall) :
    (st_ff == ST_BYTE)   ? bit_low :
    (st_ff == ST_STOP)   ? !q_fall :
    1'h0;

  always_comb begin
    nxt_st        = st_ff;
    nxt_ph        = ph_ff;
    nxt_q         = q_ff;
    nxt_qcnt      = qcnt_ff;
    nxt_bit       = bit_ff;
    nxt_sh        = sh_ff;
    nxt_cmd       = cmd_ff;
    nxt_strap     = strap_ff;
    nxt_left      = left_ff;
    nxt_nack      = nack_ff;
    nxt_rsp       = rsp_ff;
    nxt_rsp_valid = 1'h0;
    nxt_done      = 1'h0;
    if (start_cmd) begin
      nxt_st    = ST_START;
      nxt_ph    = PH_ADDR_W;
      nxt_q     = Q_LOW;
      nxt_qcnt  = '0;
      nxt_bit   = 4'h0;
      nxt_cmd   = cmd;
      nxt_strap = strap_s;
      nxt_left  = cmd.len;
      nxt_nack  = 1'h0;
    end else if (!idle && !scl_hold) begin
      if (!qtick) begin
        nxt_qcnt = qcnt_ff + 6'h1;
      end else begin
        nxt_qcnt = '0;
        nxt_q    = q_ff + 2'h1;
        // sample at the end of q_high, just before scl is pulled low
        if (st_ff == ST_BYTE && q_high) begin
          if (ack_slot && tx_mode) begin
            nxt_nack = dev_nack;
          end else if (!ack_slot && !tx_mode) begin
            nxt_sh = {sh_ff[6:0], sda_s};
          end
        end
        if (q_fall) begin
          case (st_ff)
            ST_START: begin
              nxt_st  = ST_BYTE;
              nxt_bit = 4'h0;
              nxt_sh  = slave_byte(strap_ff, 1'h0);
            end
            ST_RSTART: begin
              nxt_st  = ST_BYTE;
              nxt_bit = 4'h0;
              nxt_sh  = slave_byte(strap_ff, 1'h1);
            end
            ST_STOP: begin
              nxt_st   = ST_IDLE;
              nxt_done = 1'h1;
            end
            ST_BYTE: begin
              if (!ack_slot) begin
                nxt_bit = bit_ff + 4'h1;
                if (tx_mode) begin
                  nxt_sh = {sh_ff[6:0], 1'h0};
                end
              end else begin
                nxt_bit = 4'h0;
                case (ph_ff)
                  PH_ADDR_W: begin
                    if (nack_ff) begin
                      nxt_st = ST_STOP;
                    end else begin
                      nxt_ph = PH_PTR;
                      nxt_sh = cmd_ff.ptr;
                    end
                  end
                  PH_PTR: begin
                    if (nack_ff) begin
                      nxt_st = ST_STOP;
                    end else if (cmd_ff.rd) begin
                      nxt_st = ST_RSTART;
                      nxt_ph = PH_ADDR_R;
                    end else begin
                      nxt_ph = PH_DATA;
                      nxt_sh = cmd_ff.wdata;
                    end
                  end
                  PH_DATA: begin
                    nxt_st = ST_STOP;
                  end
                  PH_ADDR_R: begin
                    if (nack_ff) begin
                      nxt_st = ST_STOP;
                    end else begin
                      nxt_ph = PH_READ;
                      nxt_sh = 8'h00;
                    end
                  end
                  PH_READ: begin
                    nxt_rsp_valid = 1'h1;
                    nxt_rsp.data  = sh_ff;
                    nxt_rsp.last  = last_read;
                    if (last_read) begin
                      nxt_st = ST_STOP;
                    end else begin
                      nxt_left = left_ff - 3'h1;
                    end
                  end
                  default: begin
                    nxt_st = ST_STOP;
                  end
                endcase
              end
            end
            default: begin
              nxt_st = ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff   <= ST_IDLE;
      ph_ff   <= PH_ADDR_W;
      q_ff    <= Q_LOW;
      qcnt_ff <= '0;
      bit_ff  <= 4'h0;
    end else begin
      st_ff   <= nxt_st;
      ph_ff   <= nxt_ph;
      q_ff    <= nxt_q;
      qcnt_ff <= nxt_qcnt;
      bit_ff  <= nxt_bit;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sh_ff    <= 8'h00;
      cmd_ff   <= '0;
      strap_ff <= 1'h0;
      left_ff  <= 3'h0;
      nack_ff  <= 1'h0;
    end else begin
      sh_ff    <= nxt_sh;
      cmd_ff   <= nxt_cmd;
      strap_ff <= nxt_strap;
      left_ff  <= nxt_left;
      nack_ff  <= nxt_nack;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rsp_ff       <= '0;
      rsp_valid_ff <= 1'h0;
      done_ff      <= 1'h0;
      scl_oe_ff    <= 1'h0;
      sda_oe_ff    <= 1'h0;
    end else begin
      rsp_ff       <= nxt_rsp;
      rsp_valid_ff <= nxt_rsp_valid;
      done_ff      <= nxt_done;
      scl_oe_ff    <= nxt_scl_oe;
      sda_oe_ff    <= nxt_sda_oe;
    end
  end

  // open drain: only ever pull low
  assign scl_o     = 1'h0;
  assign sda_o     = 1'h0;
  assign scl_oe    = scl_oe_ff;
  assign sda_oe    = sda_oe_ff;
  assign cmd_ready = idle;
  assign busy      = !idle;
  assign rsp       = rsp_ff;
  assign rsp_valid = rsp_valid_ff;
  assign done      = done_ff;
  // nack flag stays valid until the next command is taken
  assign done_nack = nack_ff;

endmodule // i2c_host_ctrl

`default_nettype wire

// ---- i2c_host_ctrl_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

module i2c_host_ctrl_sva
  import i2c_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire rsp_s rsp,
  input wire logic done,
  input wire logic done_nack,
  input wire logic busy,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] hi_ff;
  logic [7:0] age_ff;
  // saturating: cycles with scl released, cycles since host last pulled sda
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_ff  <= 8'h00;
      age_ff <= 8'hff;
    end else begin
      hi_ff  <= scl_oe ? 8'h00 : hi_ff + {7'h00, hi_ff != 8'hff};
      age_ff <= sda_oe ? 8'h00 : age_ff + {7'h00, age_ff != 8'hff};
    end
  end
  AST_PINS_LOW: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain data pin not zero");
  AST_IDLE_FREE: assert property (!busy |-> !scl_oe && !sda_oe)
    else $error("line pulled while idle");
  AST_SCL_HIGH: assert property ($rose(scl_oe) |-> hi_ff >= 8'h1f)
    else $error("scl high phase too short");
  AST_START: assert property ($rose(sda_oe) && !scl_oe |=> !scl_oe [*8])
    else $error("scl fell too soon after start");
  AST_STOP: assert property ($fell(sda_oe) && !scl_oe |-> ##[0:80] done)
    else $error("no done after stop");
  AST_CMD_START: assert property (cmd_valid && cmd_ready |=> busy ##[0:100] (sda_oe && !scl_oe))
    else $error("command did not open a transfer");
  AST_READ_ACK: assert property (rsp_valid && !rsp.last |-> age_ff < 8'h40)
    else $error("read byte not acknowledged");
  AST_LAST_NACK: assert property (rsp_valid && rsp.last |-> age_ff >= 8'h40 ##[1:300] done)
    else $error("last byte acknowledged or no stop");
  COV_WRITE: cover property (done && !done_nack);
  COV_LAST: cover property (rsp_valid && rsp.last);
  COV_NACK: cover property (done && done_nack);
endmodule // i2c_host_ctrl_sva

bind i2c_host_ctrl i2c_host_ctrl_sva u_sva (.clk, .rst_n, .cmd_valid, .cmd_ready, .rsp_valid,
  .rsp, .done, .done_nack, .busy, .scl_o, .scl_oe, .sda_o, .sda_oe);

`default_nettype wire

// ---- i2c_host_pkg.sv ----
`default_nettype none

package i2c_host_pkg;

  // system clock and bus speed
  localparam int CLK_PERIOD_NS     = 20;
  localparam int SCL_MIN_PERIOD_NS = 2500;  // 400 kHz ceiling
  // quarter of an scl period, rounded up so the bus never runs too fast
  localparam int QTR_CYC =
    (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int QTR_W = 6;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

  // quarters of one scl cycle
  localparam logic [1:0] Q_LOW  = 2'h0;
  localparam logic [1:0] Q_RISE = 2'h1;
  localparam logic [1:0] Q_HIGH = 2'h2;
  localparam logic [1:0] Q_FALL = 2'h3;

  // bit slots of a byte: 0..7 data, 8 acknowledge
  localparam logic [3:0] BIT_ACK = 4'h8;

  // slave write byte with the strap low; strap sets bit 1
  localparam logic [7:0] SLAVE_WR_BASE = 8'hb4;
  localparam int         STRAP_BIT     = 1;

  // register pointers of the sensor
  localparam logic [7:0] PTR_INT_STATUS = 8'h00;
  localparam logic [7:0] PTR_LUX_HIGH   = 8'h03;
  localparam logic [7:0] PTR_LUX_LOW    = 8'h04;
  localparam logic [7:0] PTR_THR_UPPER  = 8'h05;
  localparam logic [7:0] PTR_THR_LOWER  = 8'h06;
  localparam logic [7:0] PTR_THR_TIMER  = 8'h07;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RSTART, ST_BYTE, ST_STOP
  } state_e;

  typedef enum logic [2:0] {
    PH_ADDR_W, PH_PTR, PH_DATA, PH_ADDR_R, PH_READ
  } phase_e;

  typedef struct packed {
    logic       rd;     // 1: pointer write then read
    logic [7:0] ptr;    // register pointer
    logic [7:0] wdata;  // byte stored on a write
    logic [2:0] len;    // read bytes minus one
  } cmd_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rsp_s;

  function automatic logic [7:0] slave_byte(input logic strap, input logic rd);
    logic [7:0] s;
    s = 8'h00;
    s[STRAP_BIT] = strap;
    slave_byte = SLAVE_WR_BASE | s | {7'h00, rd};
  endfunction

endpackage

`default_nettype wire

// ---- light_sensor_i2c_slave_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module light_sensor_i2c_slave_tb_top
  import i2c_host_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic host_strap = 1'b0;
  logic dev_strap = 1'b0;
  logic cmd_ready, rsp_valid, done, done_nack, busy, scl_o, scl_oe, sda_o, sda_oe, dev_pull;
  cmd_s cmd = '0;
  rsp_s rsp;
  rsp_s got [$];
  int   failures = 0;
  int   checked = 0;
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe | dev_pull);

  always #10 clk = ~clk;

  i2c_host_ctrl u_dut (.clk, .rst_n, .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp, .done,
    .done_nack, .busy, .address_strap_pin(host_strap), .scl_i(scl), .scl_o, .scl_oe,
    .sda_i(sda), .sda_o, .sda_oe);
  light_sensor_model u_sensor (.scl, .sda, .strap(dev_strap), .sda_pull(dev_pull));

  task automatic end_sim();
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strap synchronisers need a few cycles before the command is taken
  task automatic run(input cmd_s c);
    int n;
    got.delete();
    repeat (8) @(posedge clk);
    #1 cmd = c;
    cmd_valid = 1'b1;
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(posedge clk) #1;
    if (n >= 50) begin
      failures++;
      end_sim();
    end
    @(posedge clk) #1 cmd_valid = 1'b0;
    for (n = 0; n < 60000 && done !== 1'b1; n++) begin
      @(posedge clk) #1;
      if (rsp_valid === 1'b1) got.push_back(rsp);
    end
    if (n >= 60000) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic t_write(input logic s, input logic [7:0] p, input logic [7:0] d);
    host_strap = s;
    dev_strap = s;
    run('{1'b0, p, d, 3'h0});
    chk("stored", 16'(u_sensor.mem[p[2:0]]), 16'(d));
    chk("write nack", 16'(done_nack), 16'h0000);
  endtask

  task automatic t_read(input logic [7:0] p, input logic [2:0] len, input logic [7:0] exp);
    run('{1'b1, p, 8'h00, len});
    chk("rsp count", 16'(got.size()), 16'(len) + 16'h0001);
    foreach (got[i]) chk("rsp", 16'(got[i]), 16'({exp, i == int'(len)}));
    chk("read nack", 16'(done_nack), 16'h0000);
  endtask

  task automatic t_mismatch();
    host_strap = 1'b1;
    dev_strap = 1'b0;
    run('{1'b0, PTR_THR_LOWER, 8'h55, 3'h0});
    chk("addr nack", 16'(done_nack), 16'h0001);
    chk("untouched", 16'(u_sensor.mem[6]), 16'h0016);
    chk("scl idle", 16'(scl), 16'h0001);
    chk("sda idle", 16'(sda), 16'h0001);
    run('{1'b1, PTR_LUX_HIGH, 8'h00, 3'h0});
    chk("no read data", 16'(got.size()), 16'h0000);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    t_write(1'b0, PTR_THR_UPPER, 8'ha0);
    t_write(1'b1, PTR_THR_TIMER, 8'h5c);
    t_read(PTR_THR_UPPER, 3'h1, 8'ha0);
    t_read(PTR_INT_STATUS, 3'h0, 8'h10);
    t_read(PTR_LUX_LOW, 3'h0, 8'h14);
    t_read(PTR_LUX_HIGH, 3'h7, 8'h13);
    t_mismatch();
    end_sim();
  end
endmodule // light_sensor_i2c_slave_tb_top

`default_nettype wire

// ---- light_sensor_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module light_sensor_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic strap,
  output logic      sda_pull
);
  logic [7:0] mem [8];  // pointers 0x00 to 0x07
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic       ps;
  logic       pd;
  int         slot;
  int         ph;  // 0 ignore, 1 addr, 2 ptr, 3 data, 4 read, 5 read pending
  initial begin
    sda_pull = 1'b0;
    ps = 1'b1;
    pd = 1'b1;
    ph = 0;
    slot = 0;
    ptr = 8'h00;
    for (int i = 0; i < 8; i++) mem[i] = 8'h10 + 8'(i);
  end
  // event driven on both lines; only sees the wired level
  always @(scl or sda) begin
    if (scl && ps && pd && !sda) begin
      ph = 1;
      slot = -1;
      sda_pull = 1'b0;
    end else if (scl && ps && !pd && sda) begin
      ph = 0;
      sda_pull = 1'b0;
    end else if (scl && !ps && ph != 0) begin
      if (slot < 8) sh = {sh[6:0], sda};
      else if (ph == 4 && sda) ph = 0;  // master nack ends the read
    end else if (!scl && ps && ph != 0) begin
      slot = (slot == 8) ? 0 : slot + 1;
      sda_pull = 1'b0;
      if (slot == 8 && ph == 1) begin
        sda_pull = (sh[7:1] == {6'h2d, strap});
        ph = sda_pull ? (sh[0] ? 5 : 2) : 0;
      end else if (slot == 8 && ph == 2) begin
        ptr = sh;
        ph = 3;
        sda_pull = 1'b1;
      end else if (slot == 8 && ph == 3) begin
        mem[ptr[2:0]] = sh;
        sda_pull = 1'b1;
      end else if (slot == 0 && ph >= 4) begin
        ph = 4;
        tx = mem[ptr[2:0]];
      end
      if (slot < 8 && ph == 4) sda_pull = !tx[7-slot];
    end
    ps = scl;
    pd = sda;
  end
endmodule // light_sensor_model

`default_nettype wire

// ---- pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module pin_sync
  import i2c_host_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_sync_n,
  input  wire logic pin,
  output logic      level
);

  logic [2:0] sync_ff;
  logic       level_ff;

  // bus lines rest high, so reset to the idle level
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync_ff  <= 3'h7;
      level_ff <= 1'h1;
    end else begin
      sync_ff <= {sync_ff[1:0], pin};
      if (sync_ff[1] == sync_ff[2]) begin
        level_ff <= sync_ff[2];
      end
    end
  end

  assign level = level_ff;

endmodule // pin_sync

`default_nettype wire
